// *** inc/dcd_pkg.sv ***
// constants for the dual current dac control block
//
// Overview of operation
// - Two independent outputs each offer fifteen nonzero sink and source settings.
// - Output zero is set by the register at address f8 and output one by the one at f9.
// - Bit 7 selects sink when zero and source when one, and it is zero after power-on.
// - Bits 3 to 0 form the magnitude code, which is zero after power-on.
// - A magnitude code of zero gives zero current whatever the direction bit holds.
// - After power-up both outputs give zero current until the host writes a setting.
// - Each code step adds one fifteenth of full scale to the output current.
// - Each output takes its full scale from its own calibration input.
// - The serial port works with standard-mode and fast-mode bus clocks up to 400 kHz.
// - The device answers the address byte 90h for write and 91h for read.
// - After a mismatched address the device ignores the bus until the next start.
package dcd_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_OUTPUT0_SETTING = 8'hf8;
	localparam logic [7:0] ADDR_OUTPUT1_SETTING = 8'hf9;
	localparam logic [7:0] SETTING_RESET        = 8'h00;
	localparam logic [7:0] SETTING_WRITE_MASK   = 8'h8f;
	localparam int         DIRECTION_BIT        = 7;
	localparam int         CODE_MSB             = 3;
	localparam int         CODE_LSB             = 0;
	localparam int         CODE_STEPS           = 15;
	localparam logic [7:0] UNMAPPED_READ        = 8'h00;
	// ==========================================================
	// serial port
	localparam logic [6:0] SLAVE_ADDRESS        = 7'h48;
	localparam int         BUS_MAX_KHZ          = 400;
	localparam int         SYS_CLK_KHZ          = 50000;
	localparam int         SCL_MIN_CYCLES       = SYS_CLK_KHZ / BUS_MAX_KHZ;
	localparam logic [3:0] BITS_PER_BYTE        = 4'h8;
	// ==========================================================
	// byte engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_MEM,
		ST_WDATA,
		ST_RDATA,
		ST_RACK,
		ST_IGNORE
	} dcd_state_type;
endpackage : dcd_pkg

// *** rtl/dcd_sync.sv ***
// two flip-flop synchroniser for pins from outside the clock domain
module dcd_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_value,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// ==========================================================
	// first stage feeds only the second stage
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			meta     <= reset_value;
			sync_out <= reset_value;
		end
		else if (clk_en)
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : dcd_sync

// *** rtl/dcd_dual_current_dac.sv ***
// bus slave, setting registers and current computation for two outputs
module dcd_dual_current_dac #(
	parameter int FS_W = 12
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic [FS_W-1:0]   range_calibration_input_zero,
	input  wire logic [FS_W-1:0]   range_calibration_input_one,
	output logic      [FS_W-1:0]   current_output_zero,
	output logic                   current_output_zero_source,
	output logic                   current_output_zero_sink,
	output logic      [FS_W-1:0]   current_output_one,
	output logic                   current_output_one_source,
	output logic                   current_output_one_sink,
	output logic      [7:0]        output0_current_setting,
	output logic      [7:0]        output1_current_setting
);
	import dcd_pkg::*;

	localparam int SW = 2 + 2 * FS_W;

	// ==========================================================
	// pin synchronisers
	logic [SW-1:0]   sync_raw;
	logic [SW-1:0]   sync_val;
	logic            scl_s;
	logic            sda_s;
	logic            scl_d;
	logic            sda_d;
	logic [FS_W-1:0] fs_val [2];

	dcd_sync #(
		.WIDTH (SW)
	) u_sync (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.async_in    (sync_raw),
		.reset_value ('1),
		.sync_out    (sync_val)
	);

	assign sync_raw  = {range_calibration_input_one, range_calibration_input_zero, sda_in, scl_in};
	assign scl_s     = sync_val[0];
	assign sda_s     = sync_val[1];
	assign fs_val[0] = sync_val[2 +: FS_W];
	assign fs_val[1] = sync_val[2+FS_W +: FS_W];

	// ==========================================================
	// bus event decode
	wire scl_rise   = scl_s & ~scl_d;
	wire scl_fall   = ~scl_s & scl_d;
	wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// ==========================================================
	// setting registers
	logic [7:0] setting [2];
	logic [7:0] ptr;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic       ack_phase;
	logic       rack_ok;
	dcd_state_type state;
	wire        byte_done = (bit_cnt == BITS_PER_BYTE);

	wire        hit0      = (ptr == ADDR_OUTPUT0_SETTING);
	wire        hit1      = (ptr == ADDR_OUTPUT1_SETTING);
	wire [7:0]  read_val  = hit0 ? setting[0] : hit1 ? setting[1] : UNMAPPED_READ;
	wire        addr_hit  = (shreg[7:1] == SLAVE_ADDRESS);
	wire        wr_strobe = clk_en & scl_fall & ~ack_phase & byte_done & (state == ST_WDATA);
	wire [7:0]  wr_val    = shreg & SETTING_WRITE_MASK;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			setting[0] <= SETTING_RESET;
			setting[1] <= SETTING_RESET;
		end
		else if (wr_strobe)
		begin
			if (hit0)
				setting[0] <= wr_val;
			if (hit1)
				setting[1] <= wr_val;
		end
	end

	// ==========================================================
	// byte engine
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state     <= ST_IDLE;
			ptr       <= 8'h00;
			shreg     <= 8'h00;
			bit_cnt   <= 4'h0;
			ack_phase <= 1'b0;
			rack_ok   <= 1'b0;
			sda_oe    <= 1'b0;
		end
		else if (clk_en)
		begin
			if (start_seen)
			begin
				state     <= ST_ADDR;
				bit_cnt   <= 4'h0;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end
			else if (stop_seen)
			begin
				state     <= ST_IDLE;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (state)
					ST_ADDR, ST_MEM, ST_WDATA:
					begin
						if (!ack_phase && !byte_done)
						begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					ST_RDATA:
					begin
						if (!ack_phase)
						begin
							shreg   <= {shreg[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					ST_RACK:
					begin
						rack_ok <= ~sda_s;
						if (!sda_s)
							ptr <= ptr + 8'h01;
					end
					default:
					begin
						bit_cnt <= bit_cnt;
					end
				endcase
			end
			else if (scl_fall)
			begin
				if (ack_phase)
				begin
					ack_phase <= 1'b0;
					bit_cnt   <= 4'h0;
					sda_oe    <= (state == ST_RDATA) & ~shreg[7];
				end
				else
				begin
					case (state)
						ST_ADDR:
						begin
							if (byte_done && addr_hit)
							begin
								ack_phase <= 1'b1;
								sda_oe    <= 1'b1;
								state     <= shreg[0] ? ST_RDATA : ST_MEM;
								shreg     <= read_val;
							end
							else if (byte_done)
								state <= ST_IGNORE;
						end
						ST_MEM:
						begin
							if (byte_done)
							begin
								ptr       <= shreg;
								ack_phase <= 1'b1;
								sda_oe    <= 1'b1;
								state     <= ST_WDATA;
							end
						end
						ST_WDATA:
						begin
							if (byte_done)
							begin
								ptr       <= ptr + 8'h01;
								ack_phase <= 1'b1;
								sda_oe    <= 1'b1;
							end
						end
						ST_RDATA:
						begin
							if (byte_done)
							begin
								sda_oe  <= 1'b0;
								state   <= ST_RACK;
								bit_cnt <= 4'h0;
							end
							else
								sda_oe <= ~shreg[7];
						end
						ST_RACK:
						begin
							if (rack_ok)
							begin
								state  <= ST_RDATA;
								shreg  <= read_val;
								sda_oe <= ~read_val[7];
							end
							else
								state <= ST_IGNORE;
						end
						default:
						begin
							sda_oe <= 1'b0;
						end
					endcase
				end
			end
		end
	end

	assign sda_out = 1'b0;

	// ==========================================================
	// current computation per output
	logic [FS_W-1:0] amount [2];
	logic            src    [2];
	logic            snk    [2];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_out
			wire [3:0]      code    = setting[ch][CODE_MSB:CODE_LSB];
			wire            dir     = setting[ch][DIRECTION_BIT];
			wire            nonzero = (code != 4'h0);
			wire [FS_W+3:0] prod    = {4'h0, fs_val[ch]} * {{FS_W{1'b0}}, code};
			wire [FS_W+3:0] scaled  = prod / (FS_W+4)'(CODE_STEPS);

			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
				begin
					amount[ch] <= '0;
					src[ch]    <= 1'b0;
					snk[ch]    <= 1'b0;
				end
				else if (clk_en)
				begin
					amount[ch] <= scaled[FS_W-1:0];
					src[ch]    <= nonzero & dir;
					snk[ch]    <= nonzero & ~dir;
				end
			end
		end
	endgenerate

	assign current_output_zero        = amount[0];
	assign current_output_zero_source = src[0];
	assign current_output_zero_sink   = snk[0];
	assign current_output_one         = amount[1];
	assign current_output_one_source  = src[1];
	assign current_output_one_sink    = snk[1];
	assign output0_current_setting    = setting[0];
	assign output1_current_setting    = setting[1];
endmodule : dcd_dual_current_dac

// *** tb/dcd_checker.sv ***
// port assertions for the dual current dac block
module dcd_checker
	import dcd_pkg::*;
#(
	parameter int FS_W = 12
) (
	input wire logic            sys_clk,
	input wire logic            rst_n,
	input wire logic            scl_in,
	input wire logic            sda_oe,
	input wire logic [FS_W-1:0] range_calibration_input_zero,
	input wire logic [FS_W-1:0] range_calibration_input_one,
	input wire logic [FS_W-1:0] current_output_zero,
	input wire logic            current_output_zero_source,
	input wire logic            current_output_zero_sink,
	input wire logic [FS_W-1:0] current_output_one,
	input wire logic            current_output_one_source,
	input wire logic            current_output_one_sink,
	input wire logic [7:0]      output0_current_setting,
	input wire logic [7:0]      output1_current_setting
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// helpers
	wire logic [7:0]      s0 = output0_current_setting;
	wire logic [7:0]      s1 = output1_current_setting;
	wire logic [1:0]      f0 = {current_output_zero_source, current_output_zero_sink};
	wire logic [1:0]      f1 = {current_output_one_source, current_output_one_sink};
	wire logic [FS_W+3:0] p0 = range_calibration_input_zero * s0[3:0];
	wire logic [FS_W+3:0] p1 = range_calibration_input_one * s1[3:0];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// assertions
	a_quiet_zero: assert property (s0[3:0] == 4'h0 |=> f0 == 2'b00)
		else $error("output zero flags set at code zero");
	a_source_zero: assert property (s0[3:0] != 4'h0 && s0[7] |=> f0 == 2'b10)
		else $error("output zero not sourcing");
	a_sink_one: assert property (s1[3:0] != 4'h0 && !s1[7] |=> f1 == 2'b01)
		else $error("output one not sinking");
	a_scale_zero: assert property (
		current_output_zero == FS_W'($past(p0) / CODE_STEPS))
		else $error("output zero magnitude wrong");
	a_scale_one: assert property (
		current_output_one == FS_W'($past(p1) / CODE_STEPS))
		else $error("output one magnitude wrong");
	a_reserved_clear: assert property (((s0 | s1) & 8'h70) == 8'h00)
		else $error("reserved bits set");
	a_reset_clear: assert property (disable iff (1'b0)
		!rst_n |=> s0 == 8'h00 && s1 == 8'h00 && !sda_oe)
		else $error("reset left state");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data pin moved while clock high");
	a_set_scl_low: assert property ($changed({s0, s1}) |-> !scl_in)
		else $error("setting changed while clock high");
endmodule : dcd_checker

bind dcd_dual_current_dac dcd_checker #(.FS_W(FS_W)) u_checker (.*);

// *** tb/dcd_i2c_master.sv ***
// bus master model driving the serial port, open-drain data
module dcd_i2c_master (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// bus phases of four cycles, a 160 ns bus clock
	localparam int HALF = 4;
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic st(input logic c, input logic d, input int n);
		scl <= c;
		sda_drv <= d;
		repeat (n) @(posedge sys_clk);
	endtask : st
	// data falls while clock high
	task automatic start;
		st(scl, 1'b1, HALF);
		st(1'b1, 1'b1, HALF);
		st(1'b1, 1'b0, HALF);
		st(1'b0, 1'b0, HALF);
	endtask : start
	// data rises while clock high
	task automatic stop;
		st(1'b0, 1'b0, HALF);
		st(1'b1, 1'b0, HALF);
		st(1'b1, 1'b1, HALF);
	endtask : stop
	// nine bits msb first, a one releases the line
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			st(1'b0, tx[i], HALF / 2);
			st(1'b1, tx[i], HALF / 2);
			rx[i] = sda_line;
			st(1'b1, tx[i], HALF / 2);
			st(1'b0, tx[i], HALF / 2);
		end
	endtask : xfer
endmodule : dcd_i2c_master

// *** tb/dual_current_dac_control_tb.sv ***
// self-checking bench for the dual current dac block
module dual_current_dac_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dcd_pkg::*;
	// ==========================================================
	// clock, reset and wiring
	localparam int CAL0 = 900;
	localparam int CAL1 = 3000;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        sda_out;
	logic        scl;
	logic        sda_drv;
	logic        sda_oe;
	logic [1:0]  f0;
	logic [1:0]  f1;
	logic [11:0] i0;
	logic [11:0] i1;
	logic [7:0]  o0;
	logic [7:0]  o1;
	logic [8:0]  rx;
	logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'ha, 4'hf};
	int          n_errors = 0;
	int          check_count = 0;
	wire logic   sda_line = sda_drv & (sda_out | ~sda_oe);
	initial forever #10 sys_clk = ~sys_clk;
	dcd_dual_current_dac #(.FS_W(12)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .range_calibration_input_zero(12'(CAL0)),
		.range_calibration_input_one(12'(CAL1)), .current_output_zero(i0),
		.current_output_zero_source(f0[1]), .current_output_zero_sink(f0[0]),
		.current_output_one(i1), .current_output_one_source(f1[1]),
		.current_output_one_sink(f1[0]), .output0_current_setting(o0),
		.output1_current_setting(o1));
	dcd_i2c_master m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		n_errors += int'(got !== exp);
	endtask : chk
	task automatic send(input logic [7:0] b, input logic nack);
		m.xfer({b, 1'b1}, rx);
		chk(16'(rx[0]), 16'(nack));
	endtask : send
	task automatic wr(input logic [7:0] sa, a, d0, d1);
		logic n;
		n = (sa != 8'h90);
		m.start();
		send(sa, n);
		send(a, n);
		send(d0, n);
		send(d1, n);
		m.stop();
	endtask : wr
	// ==========================================================
	// scenarios
	task automatic sc_reset;
		chk({o0, o1}, 16'h0000);
		chk({i0, f0, f1}, 16'h0000);
		chk({i1, sda_out, 3'h0}, 16'h0000);
	endtask : sc_reset
	// both outputs, opposite directions, reserved bits written as 111 on output zero and 101 on output one
	task automatic sc_codes;
		logic [3:0] c;
		logic       s;
		for (int k = 0; k < 8; k++)
		begin
			c = codes[k % 4];
			s = (k > 3);
			wr(8'h90, ADDR_OUTPUT0_SETTING, {s, 3'h7, c}, {!s, 3'h5, c});
			chk({o0, o1}, {s, 3'h0, c, !s, 3'h0, c});
			chk(16'(i0), 16'(CAL0 * c / CODE_STEPS));
			chk(16'(i1), 16'(CAL1 * c / CODE_STEPS));
			chk(16'({f0, f1}), 16'({s, !s, !s, s} & {4{c != 4'h0}}));
		end
	endtask : sc_codes
	task automatic sc_wrong;
		wr(8'h92, ADDR_OUTPUT0_SETTING, 8'h81, 8'h81);
		chk({o0, o1}, 16'h8f0f);
	endtask : sc_wrong
	// a whole write while the clock enable is low must leave no trace
	task automatic sc_freeze;
		clk_en <= 1'b0;
		m.start();
		send(8'h90, 1'b1);
		send(ADDR_OUTPUT0_SETTING, 1'b1);
		send(8'h01, 1'b1);
		m.stop();
		chk({o0, o1}, 16'h8f0f);
		chk({i0, f0, f1}, {12'(CAL0), 4'h9});
		clk_en <= 1'b1;
	endtask : sc_freeze
	// two bytes, the first acknowledged so the pointer moves on
	task automatic sc_read(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
		m.start();
		send(8'h90, 1'b0);
		send(a, 1'b0);
		m.start();
		send(8'h91, 1'b0);
		m.xfer(9'h1fe, rx);
		chk(16'(rx[8:1]), 16'(e0));
		m.xfer(9'h1ff, rx);
		chk(16'(rx[8:1]), 16'(e1));
		m.stop();
	endtask : sc_read
	task automatic tally_and_finish;
		$display("checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		sc_reset();
		sc_codes();
		sc_wrong();
		sc_freeze();
		sc_read(8'hf8, 8'h8f, 8'h0f);
		sc_read(8'hf9, 8'h0f, UNMAPPED_READ);
		tally_and_finish();
	end
	// about ten thousand clocks, over twice the expected run
	initial
	begin
		#200000;
		n_errors++;
		tally_and_finish();
	end
endmodule : dual_current_dac_control_tb
